// ===== rtl/csr_bank_pkg.sv
// constants and carriers for the control and status register bank
// assumes a core that drives one register bus access per cycle
`default_nettype none
package csr_bank_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 5;

  // variant selector
  typedef enum logic [1:0] {
    VAR_BASE,
    VAR_SMALL_STACK,
    VAR_MAC
  } variant_e;

  // register addresses
  localparam logic [4:0] ADDR_INTERRUPT_MASK = 5'h08;
  localparam logic [4:0] ADDR_STACK_POINTERS = 5'h09;
  localparam logic [4:0] ADDR_UNDERFLOW_LIMITS = 5'h0A;
  localparam logic [4:0] ADDR_VECTOR_LIMITS = 5'h0B;
  localparam logic [4:0] ADDR_RETURN_PAGE = 5'h0C;
  localparam logic [4:0] ADDR_DATA_PAGE = 5'h0D;
  localparam logic [4:0] ADDR_USER_PAGE = 5'h0E;
  localparam logic [4:0] ADDR_CODE_PAGE = 5'h0F;
  localparam logic [4:0] ADDR_BASE_CONTROL = 5'h10;
  localparam logic [4:0] ADDR_USER_BLOCK_BASE = 5'h11;
  localparam logic [4:0] ADDR_ACC_EXTENSION = 5'h12;
  localparam logic [4:0] ADDR_TIMER0 = 5'h13;
  localparam logic [4:0] ADDR_TIMER1 = 5'h14;
  localparam logic [4:0] ADDR_TIMER2 = 5'h15;
  localparam logic [4:0] ADDR_LOW_WORD = 5'h16;
  localparam logic [4:0] ADDR_HIGH_WORD = 5'h17;

  // field layout and reset values
  localparam logic [15:0] MASK_WRITABLE = 16'h3FFE;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [7:0] LIMIT_RESET = 8'hFF;
  localparam logic [7:0] LIMIT_MAX_SMALL = 8'h40;
  localparam int unsigned PS_LSB = 0;
  localparam int unsigned RS_LSB = 8;
  localparam int unsigned SELECT_BIT = 5;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned RET_PAGE_W = 5;
  localparam logic [15:0] NO_VECTOR = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [3:0] PAGE_RESET = 4'h0;
  localparam logic [4:0] RET_PAGE_RESET = 5'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_ONE = 8'h01;
  localparam logic [15:0] WORD_ONE = 16'h0001;

  // one register bus access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } bus_req_s;

  // return stack top update from calls, returns, index accesses
  typedef struct packed {
    logic load;
    logic [4:0] page;
  } ret_page_upd_s;

endpackage
`default_nettype wire

// ===== rtl/scratch_counter.sv
// scratch counting word with one cycle increment and decrement
// assumes load, inc and dec come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module scratch_counter
  import csr_bank_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic inc,
  input wire logic dec,
  output logic [15:0] count_ff
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // load beats inc/dec; plain add wraps at both ends by itself
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count_ff <= ZERO_WORD;
    end else if (load) begin
      count_ff <= load_value;
    end else if (inc && !dec) begin
      count_ff <= count_ff + WORD_ONE;
    end else if (dec && !inc) begin
      count_ff <= count_ff - WORD_ONE;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/csr_bank.sv
// control and status register bank of the stack processor, 08h..17h
// assumes the core pushes rdata_ff when rd is taken and pops wdata on wr
`timescale 1ns/100ps
`default_nettype none
module csr_bank
  import csr_bank_pkg::*;
#(
  parameter variant_e VARIANT = VAR_BASE
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire bus_req_s bus_req,
  input wire ret_page_upd_s ret_page_upd,
  input wire logic [13:0] irq_raw,
  input wire logic [15:0] live_vector,
  input wire logic [7:0] param_ptr_live,
  input wire logic [7:0] return_ptr_live,
  input wire logic [15:0] timer0_count,
  input wire logic [15:0] timer1_count,
  input wire logic [15:0] timer2_count,
  input wire logic [15:0] product_low_live,
  input wire logic [15:0] product_high_live,
  input wire logic [15:0] acc_ext_live,
  input wire logic acc_ext_load,
  input wire logic scratch_inc,
  input wire logic scratch_dec,
  output logic [15:0] rdata_ff,
  output logic head_to_second_ff,
  output logic [13:0] irq_masked_ff,
  output logic clear_timer_irq_ff,
  output logic ptr_load_ff,
  output logic [7:0] param_ptr_ff,
  output logic [7:0] return_ptr_ff,
  output logic [7:0] param_limit_ff,
  output logic [7:0] return_limit_ff,
  output logic [7:0] param_under_ff,
  output logic [7:0] return_under_ff,
  output logic [4:0] return_page_ff,
  output logic [3:0] fetch_page_ff,
  output logic [3:0] data_ref_page_ff,
  output logic [3:0] user_page_ff,
  output logic [15:0] base_control_ff,
  output logic [15:0] user_block_base_ff,
  output logic [15:0] acc_extension_ff,
  output logic [15:0] low_word_ff,
  output logic [15:0] high_word_ff,
  output logic [2:0] preload_we_ff,
  output logic [15:0] preload_data_ff
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [15:0] interrupt_mask_ff;
  logic [3:0] data_page_ff;
  logic [3:0] code_page_ff;
  logic [15:0] scratch_count;
  logic [15:0] nxt_rdata;
  logic wr;
  logic rd;
  logic [4:0] a;
  logic [15:0] wd;

  assign wr = bus_req.wr;
  assign rd = bus_req.rd;
  assign a = bus_req.addr;
  assign wd = bus_req.wdata;

  // true when a write at this address hits
  function automatic logic hit(input logic [4:0] want);
    hit = wr && (a == want);
  endfunction

  // clamp one limit to the variant ceiling
  function automatic logic [7:0] clamp_limit(input logic [7:0] v);
    if (VARIANT == VAR_SMALL_STACK && v > LIMIT_MAX_SMALL) begin
      clamp_limit = LIMIT_MAX_SMALL;
    end else begin
      clamp_limit = v;
    end
  endfunction

  // ---------------------------------------------------------------
  // interrupt mask
  // ---------------------------------------------------------------
  // reserved bits never stored, so they always read zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      interrupt_mask_ff <= MASK_RESET;
    end else if (hit(ADDR_INTERRUPT_MASK)) begin
      interrupt_mask_ff <= wd & MASK_WRITABLE;
    end
  end

  // requests on bits 13:1 of the mask; request 0 has no mask bit and always passes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_masked_ff <= 14'h0000;
    end else begin
      irq_masked_ff <= irq_raw & ~interrupt_mask_ff[13:0];
    end
  end

  // ---------------------------------------------------------------
  // stack pointers and limits
  // ---------------------------------------------------------------
  // pointer writes go to the stack controllers as a load strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ptr_load_ff <= 1'b0;
      param_ptr_ff <= PTR_RESET;
      return_ptr_ff <= PTR_RESET;
    end else begin
      ptr_load_ff <= hit(ADDR_STACK_POINTERS);
      if (hit(ADDR_STACK_POINTERS)) begin
        param_ptr_ff <= wd[PS_LSB +: 8];
        return_ptr_ff <= wd[RS_LSB +: 8];
      end
    end
  end

  // underflow limits exist only outside the base variant
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      param_under_ff <= PTR_RESET;
      return_under_ff <= PTR_RESET;
    end else if (hit(ADDR_UNDERFLOW_LIMITS) && VARIANT != VAR_BASE) begin
      param_under_ff <= wd[PS_LSB +: 8];
      return_under_ff <= wd[RS_LSB +: 8];
    end
  end

  // 0bh write: plain limits on base, overflow limits otherwise
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      param_limit_ff <= LIMIT_RESET;
      return_limit_ff <= LIMIT_RESET;
    end else if (hit(ADDR_VECTOR_LIMITS)) begin
      if (VARIANT == VAR_BASE) begin
        param_limit_ff <= wd[PS_LSB +: 8];
        return_limit_ff <= wd[RS_LSB +: 8];
      end else begin
        param_limit_ff <= clamp_limit(wd[PS_LSB +: 8]);
        return_limit_ff <= clamp_limit(wd[RS_LSB +: 8]);
      end
    end
  end

  // a vector read also clears pending timer requests, for one cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      clear_timer_irq_ff <= 1'b0;
    end else begin
      clear_timer_irq_ff <= rd && (a == ADDR_VECTOR_LIMITS);
    end
  end

  // ---------------------------------------------------------------
  // pages
  // ---------------------------------------------------------------
  // stack-side updates win: a call in the same cycle owns the top entry
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      return_page_ff <= RET_PAGE_RESET;
    end else if (ret_page_upd.load) begin
      return_page_ff <= ret_page_upd.page;
    end else if (hit(ADDR_RETURN_PAGE)) begin
      return_page_ff <= wd[RET_PAGE_W-1:0];
    end
  end

  // page registers, base control and user block base
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_page_ff <= PAGE_RESET;
      user_page_ff <= PAGE_RESET;
      code_page_ff <= PAGE_RESET;
      base_control_ff <= ZERO_WORD;
      user_block_base_ff <= ZERO_WORD;
    end else begin
      if (hit(ADDR_DATA_PAGE)) begin
        data_page_ff <= wd[PAGE_W-1:0];
      end
      if (hit(ADDR_USER_PAGE)) begin
        user_page_ff <= wd[PAGE_W-1:0];
      end
      if (hit(ADDR_CODE_PAGE)) begin
        code_page_ff <= wd[PAGE_W-1:0];
      end
      if (hit(ADDR_BASE_CONTROL)) begin
        base_control_ff <= wd;
      end
      if (hit(ADDR_USER_BLOCK_BASE)) begin
        user_block_base_ff <= wd;
      end
    end
  end

  // page steering; registered, so one cycle behind the page write
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fetch_page_ff <= PAGE_RESET;
      data_ref_page_ff <= PAGE_RESET;
    end else begin
      fetch_page_ff <= code_page_ff;
      if (base_control_ff[SELECT_BIT]) begin
        data_ref_page_ff <= data_page_ff;
      end else begin
        data_ref_page_ff <= code_page_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // accumulator extension, low and high words
  // ---------------------------------------------------------------
  // datapath loads beat bus writes; only the mac variant keeps it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      acc_extension_ff <= ZERO_WORD;
    end else if (VARIANT == VAR_MAC) begin
      if (acc_ext_load) begin
        acc_extension_ff <= acc_ext_live;
      end else if (hit(ADDR_ACC_EXTENSION)) begin
        acc_extension_ff <= wd;
      end
    end
  end

  scratch_counter i_scratch_counter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .load(hit(ADDR_LOW_WORD) && VARIANT == VAR_SMALL_STACK),
    .load_value(wd),
    .inc(scratch_inc),
    .dec(scratch_dec),
    .count_ff(scratch_count)
  );

  // low word: product on base, counter on small, writable on mac
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      low_word_ff <= ZERO_WORD;
    end else begin
      case (VARIANT)
        VAR_SMALL_STACK: low_word_ff <= scratch_count;
        VAR_MAC: begin
          if (hit(ADDR_LOW_WORD)) begin
            low_word_ff <= wd;
          end else begin
            low_word_ff <= product_low_live;
          end
        end
        default: low_word_ff <= product_low_live;
      endcase
    end
  end

  // high word: scratch store only on small; product elsewhere
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      high_word_ff <= ZERO_WORD;
    end else begin
      case (VARIANT)
        VAR_SMALL_STACK: begin
          if (hit(ADDR_HIGH_WORD)) begin
            high_word_ff <= wd;
          end
        end
        VAR_MAC: begin
          if (hit(ADDR_HIGH_WORD)) begin
            high_word_ff <= wd;
          end else begin
            high_word_ff <= product_high_live;
          end
        end
        default: high_word_ff <= product_high_live;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // timer preload strobes
  // ---------------------------------------------------------------
  // writes never touch the live count, only the preload
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      preload_we_ff <= 3'h0;
      preload_data_ff <= ZERO_WORD;
    end else begin
      preload_we_ff <= {hit(ADDR_TIMER2), hit(ADDR_TIMER1),
                        hit(ADDR_TIMER0)};
      preload_data_ff <= wd;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // reserved and unmapped addresses read zero
  always_comb begin
    nxt_rdata = ZERO_WORD;
    case (a)
      ADDR_INTERRUPT_MASK: nxt_rdata = interrupt_mask_ff;
      // pointer already counts the pushed word
      ADDR_STACK_POINTERS: nxt_rdata = {return_ptr_live,
                                        param_ptr_live + PTR_ONE};
      ADDR_UNDERFLOW_LIMITS: begin
        if (VARIANT != VAR_BASE) begin
          nxt_rdata = {return_under_ff, param_under_ff};
        end
      end
      ADDR_VECTOR_LIMITS: nxt_rdata = live_vector;
      ADDR_RETURN_PAGE: nxt_rdata = {11'h000, return_page_ff};
      ADDR_DATA_PAGE: nxt_rdata = {12'h000, data_page_ff};
      ADDR_USER_PAGE: nxt_rdata = {12'h000, user_page_ff};
      ADDR_CODE_PAGE: nxt_rdata = {12'h000, code_page_ff};
      ADDR_BASE_CONTROL: nxt_rdata = base_control_ff;
      ADDR_USER_BLOCK_BASE: nxt_rdata = user_block_base_ff;
      ADDR_ACC_EXTENSION: begin
        if (VARIANT == VAR_MAC) begin
          nxt_rdata = acc_extension_ff;
        end
      end
      ADDR_TIMER0: nxt_rdata = timer0_count;
      ADDR_TIMER1: nxt_rdata = timer1_count;
      ADDR_TIMER2: nxt_rdata = timer2_count;
      ADDR_LOW_WORD: nxt_rdata = low_word_ff;
      ADDR_HIGH_WORD: nxt_rdata = high_word_ff;
      default: nxt_rdata = ZERO_WORD;
    endcase
  end

  // one-cycle read answer, full word
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_ff <= ZERO_WORD;
      head_to_second_ff <= 1'b0;
    end else begin
      if (rd) begin
        rdata_ff <= nxt_rdata;
      end
      head_to_second_ff <= rd && VARIANT == VAR_BASE &&
        (a == ADDR_LOW_WORD || a == ADDR_HIGH_WORD);
    end
  end

endmodule
`default_nettype wire

// ===== testbench/csr_bank_properties.sv
// port assertions for the register bank
// assumes one clock, synchronous low reset
`timescale 1ns/100ps
`default_nettype none
module csr_bank_properties
  import csr_bank_pkg::*;
#(
  parameter variant_e VARIANT = VAR_BASE
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire bus_req_s bus_req,
  input wire ret_page_upd_s ret_page_upd,
  input wire logic [13:0] irq_raw,
  input wire logic [15:0] live_vector,
  input wire logic [7:0] param_ptr_live,
  input wire logic [7:0] return_ptr_live,
  input wire logic [15:0] rdata_ff,
  input wire logic head_to_second_ff,
  input wire logic [13:0] irq_masked_ff,
  input wire logic clear_timer_irq_ff,
  input wire logic ptr_load_ff,
  input wire logic [7:0] param_ptr_ff,
  input wire logic [7:0] return_ptr_ff,
  input wire logic [7:0] param_limit_ff,
  input wire logic [7:0] return_limit_ff,
  input wire logic [4:0] return_page_ff,
  input wire logic [2:0] preload_we_ff,
  input wire logic [15:0] preload_data_ff
);
  // ----
  // decode and mask shadow
  // ----
  wire logic rd = bus_req.rd;
  wire logic wr = bus_req.wr;
  wire logic [4:0] a = bus_req.addr;
  wire logic base = VARIANT == VAR_BASE;
  logic [15:0] mask_m_ff;

  // shadow keeps no reserved bits, so readback is judged strictly
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mask_m_ff <= 16'h0000;
    end else if (wr && a == 5'h08) begin
      mask_m_ff <= bus_req.wdata & 16'h3FFE;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_mask_gate: assert property ($past(resetn) |->
    irq_masked_ff == ($past(irq_raw) & ~$past(mask_m_ff[13:0])))
    else $error("masked requests wrong");
  chk_mask_read: assert property (rd && a == 5'h08 |=>
    rdata_ff == $past(mask_m_ff)) else $error("mask readback wrong");
  chk_ptr_read: assert property (rd && a == 5'h09 |=>
    rdata_ff == {$past(return_ptr_live), $past(param_ptr_live) + 8'h01})
    else $error("pointer read wrong");
  chk_ptr_write: assert property (wr && a == 5'h09 |=>
    ptr_load_ff && {return_ptr_ff, param_ptr_ff} == $past(bus_req.wdata))
    else $error("pointer write wrong");
  chk_vector_read: assert property (rd && a == 5'h0B |=>
    rdata_ff == $past(live_vector)) else $error("vector read wrong");
  chk_clear_pulse: assert property ($past(resetn) |->
    clear_timer_irq_ff == $past(rd && a == 5'h0B))
    else $error("timer clear pulse wrong");
  chk_limit_load: assert property (base && wr && a == 5'h0B |=>
    {return_limit_ff, param_limit_ff} == $past(bus_req.wdata))
    else $error("limit write wrong");
  chk_preload_pulse: assert property (wr && a inside {[5'h13:5'h15]}
    |=> preload_data_ff == $past(bus_req.wdata)
    && preload_we_ff == (3'b001 << ($past(a) - 5'h13)))
    else $error("preload strobe wrong");
  chk_page_update: assert property (ret_page_upd.load |=>
    return_page_ff == $past(ret_page_upd.page))
    else $error("return page update wrong");
  chk_head_move: assert property (base && $past(resetn) |->
    head_to_second_ff == $past(rd && (a == 5'h16 || a == 5'h17)))
    else $error("head move pulse wrong");
  chk_reserved_zero: assert property (base && rd
    && (a == 5'h0A || a == 5'h12) |=> rdata_ff == 16'h0000)
    else $error("reserved read not zero");

  chk_limit_clamp: assert property (VARIANT == VAR_SMALL_STACK && wr
    && a == 5'h0B |=> param_limit_ff <= 8'h40 && return_limit_ff <= 8'h40)
    else $error("limit above ceiling");

  cov_ptr_write: cover property (wr && a == 5'h09);
  cov_product_read: cover property (base && rd && a == 5'h16);
  cov_vector_read: cover property (rd && a == 5'h0B);
  cov_page_update: cover property (ret_page_upd.load);
endmodule

bind csr_bank csr_bank_properties #(.VARIANT(VARIANT)) i_csr_bank_properties (
  .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
  .ret_page_upd(ret_page_upd), .irq_raw(irq_raw),
  .live_vector(live_vector), .param_ptr_live(param_ptr_live),
  .return_ptr_live(return_ptr_live), .rdata_ff(rdata_ff),
  .head_to_second_ff(head_to_second_ff), .irq_masked_ff(irq_masked_ff),
  .clear_timer_irq_ff(clear_timer_irq_ff), .ptr_load_ff(ptr_load_ff),
  .param_ptr_ff(param_ptr_ff), .return_ptr_ff(return_ptr_ff),
  .param_limit_ff(param_limit_ff), .return_limit_ff(return_limit_ff),
  .return_page_ff(return_page_ff), .preload_we_ff(preload_we_ff),
  .preload_data_ff(preload_data_ff));
`default_nettype wire

// ===== testbench/core_model.sv
// core side model: register bus master and live stack pointers
// assumes its tasks are called one at a time by the bench
`timescale 1ns/100ps
`default_nettype none
module core_model
  import csr_bank_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [15:0] rdata_ff,
  output var bus_req_s bus_req,
  output var ret_page_upd_s ret_page_upd,
  output var logic [7:0] param_ptr_live,
  output var logic [7:0] return_ptr_live
);
  initial begin
    bus_req = '0;
    ret_page_upd = '0;
    param_ptr_live = 8'h10;
    return_ptr_live = 8'h20;
  end

  // a read pushes, a write pops the parameter stack
  always @(posedge ref_clk) begin
    if (bus_req.rd) begin
      param_ptr_live <= param_ptr_live + 8'h01;
    end else if (bus_req.wr) begin
      param_ptr_live <= param_ptr_live - 8'h01;
    end
  end

  // one access, held across its sampling edge; data inverted after
  task automatic access(input logic w, input logic [4:0] a,
                        input logic [15:0] d, output logic [15:0] q);
    @(posedge ref_clk);
    #1;
    bus_req.rd = !w;
    bus_req.wr = w;
    bus_req.addr = a;
    bus_req.wdata = (a == 5'h08) ? (d & 16'h3FFF) : d;
    @(posedge ref_clk);
    #1;
    q = rdata_ff;
    bus_req.rd = 1'b0;
    bus_req.wr = 1'b0;
    bus_req.wdata = ~bus_req.wdata;
  endtask

  // call or return rewriting the top page, used sparingly
  task automatic page_update(input logic [4:0] p);
    @(posedge ref_clk);
    #1;
    ret_page_upd = {1'b1, p};
    @(posedge ref_clk);
    #1;
    ret_page_upd = '0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/csr_bank_tb_top.sv
// self-checking bench for the base and small-stack register banks
// assumes core_model and the bound checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module csr_bank_tb_top;
  import csr_bank_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  bus_req_s bus_req;
  ret_page_upd_s ret_page_upd;
  logic [13:0] irq_raw = '0;
  logic [15:0] live_vector = '0;
  logic [15:0] tc [3] = '{default: '0};
  logic [15:0] p_lo = '0;
  logic [15:0] p_hi = '0;
  logic [7:0] ppl, rpl, ppf, rpf, plim, rlim;
  logic [15:0] rdata_ff, ubb, pdata, q, e;
  logic head, clr, pld;
  logic [13:0] masked;
  logic [4:0] rpage;
  logic [3:0] fpage, dpage, upage;
  logic [2:0] pwe;
  logic [7:0] pul, rul, spl, srl;
  logic [15:0] bctl, acx, lw, hw, sq;
  logic sinc = 1'b0;
  logic sdec = 1'b0;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  always #10 ref_clk = ~ref_clk;

  core_model i_core_model (.ref_clk(ref_clk), .rdata_ff(rdata_ff),
    .bus_req(bus_req), .ret_page_upd(ret_page_upd),
    .param_ptr_live(ppl), .return_ptr_live(rpl));

  // extension and scratch inputs have no role on the base variant
  csr_bank i_csr_bank (.ref_clk(ref_clk), .resetn(resetn),
    .bus_req(bus_req), .ret_page_upd(ret_page_upd), .irq_raw(irq_raw),
    .live_vector(live_vector), .param_ptr_live(ppl),
    .return_ptr_live(rpl), .timer0_count(tc[0]), .timer1_count(tc[1]),
    .timer2_count(tc[2]), .product_low_live(p_lo),
    .product_high_live(p_hi), .acc_ext_live(16'h0000),
    .acc_ext_load(1'b0), .scratch_inc(1'b0), .scratch_dec(1'b0),
    .rdata_ff(rdata_ff), .head_to_second_ff(head),
    .irq_masked_ff(masked), .clear_timer_irq_ff(clr),
    .ptr_load_ff(pld), .param_ptr_ff(ppf), .return_ptr_ff(rpf),
    .param_limit_ff(plim), .return_limit_ff(rlim), .param_under_ff(pul),
    .return_under_ff(rul), .return_page_ff(rpage), .fetch_page_ff(fpage),
    .data_ref_page_ff(dpage), .user_page_ff(upage),
    .base_control_ff(bctl), .user_block_base_ff(ubb),
    .acc_extension_ff(acx), .low_word_ff(lw), .high_word_ff(hw),
    .preload_we_ff(pwe), .preload_data_ff(pdata));

  // small-stack variant on the same bus; its read word is watched directly
  csr_bank #(.VARIANT(VAR_SMALL_STACK)) i_csr_bank_small (
    .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
    .ret_page_upd(ret_page_upd), .irq_raw(irq_raw),
    .live_vector(live_vector), .param_ptr_live(ppl),
    .return_ptr_live(rpl), .timer0_count(tc[0]), .timer1_count(tc[1]),
    .timer2_count(tc[2]), .product_low_live(p_lo),
    .product_high_live(p_hi), .acc_ext_live(16'h0000),
    .acc_ext_load(1'b0), .scratch_inc(sinc), .scratch_dec(sdec),
    .rdata_ff(sq), .head_to_second_ff(), .irq_masked_ff(),
    .clear_timer_irq_ff(), .ptr_load_ff(), .param_ptr_ff(),
    .return_ptr_ff(), .param_limit_ff(spl), .return_limit_ff(srl),
    .param_under_ff(), .return_under_ff(), .return_page_ff(),
    .fetch_page_ff(), .data_ref_page_ff(), .user_page_ff(),
    .base_control_ff(), .user_block_base_ff(), .acc_extension_ff(),
    .low_word_ff(), .high_word_ff(), .preload_we_ff(),
    .preload_data_ff());

  // ----
  // bus helpers and scenarios
  // ----
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_core_model.access(1'b1, a, d, e);
  endtask
  task automatic rd(input logic [4:0] a);
    i_core_model.access(1'b0, a, 16'h0000, q);
  endtask
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset_mask;
    `CHK("limits", 16'hFFFF, {rlim, plim})
    rd(5'h08);
    `CHK("mask reset", 16'h0000, q)
    irq_raw = 14'h3FFF;
    wr(5'h08, 16'hFFFF);
    rd(5'h08);
    `CHK("mask read", 16'h3FFE, q)
    `CHK("masked all", 14'h0001, masked)
    wr(5'h08, 16'h00AA);
    settle;
    `CHK("masked some", 14'h3F55, masked)
  endtask

  task automatic t_pointers_limits;
    wr(5'h09, 16'h3456);
    `CHK("ptr bytes", 17'h13456, {pld, rpf, ppf})
    e = {rpl, ppl + 8'h01};
    rd(5'h09);
    `CHK("ptr read", e, q)
    live_vector = 16'h0123;
    rd(5'h0B);
    `CHK("vector", 17'h10123, {clr, q})
    wr(5'h0B, 16'hA55A);
    `CHK("limit load", 16'hA55A, {rlim, plim})
  endtask

  task automatic t_reserved_products;
    wr(5'h0A, 16'hBEEF);
    `CHK("under kept", 16'h0000, {rul, pul})
    rd(5'h0A);
    `CHK("addr 0A", 16'h0000, q)
    wr(5'h12, 16'hBEEF);
    `CHK("ext kept", 16'h0000, acx)
    rd(5'h12);
    `CHK("addr 12", 16'h0000, q)
    p_lo = 16'h1111;
    p_hi = 16'h2222;
    wr(5'h16, 16'h0000);
    wr(5'h17, 16'h0000);
    rd(5'h16);
    `CHK("product low", 17'h11111, {head, q})
    `CHK("product words", 32'h22221111, {hw, lw})
    rd(5'h17);
    `CHK("product high", 16'h2222, q)
  endtask

  task automatic t_pages;
    wr(5'h0C, 16'hFFF3);
    `CHK("page write", 5'h13, rpage)
    i_core_model.page_update(5'h0A);
    `CHK("page upd", 5'h0A, rpage)
    rd(5'h0C);
    `CHK("page read", 16'h000A, q)
    wr(5'h0D, 16'h0005);
    wr(5'h0E, 16'h0003);
    wr(5'h0F, 16'h0009);
    wr(5'h11, 16'h0420);
    settle;
    `CHK("code pages", 8'h99, {fpage, dpage})
    `CHK("user page", 4'h3, upage)
    `CHK("user base", 16'h0420, ubb)
    wr(5'h10, 16'h0020);
    settle;
    `CHK("data page", 4'h5, dpage)
    `CHK("base ctl", 16'h0020, bctl)
  endtask

  task automatic t_timers;
    for (int n = 0; n < 3; n++) begin
      tc[n] = 16'h7000 + 16'(n);
      wr(5'h13 + 5'(n), 16'hC000 + 16'(n));
      `CHK("preload", 3'b001 << n, pwe)
      `CHK("preload data", 16'hC000 + 16'(n), pdata)
      rd(5'h13 + 5'(n));
      `CHK("count", 16'h7000 + 16'(n), q)
    end
  endtask

  // clamp, underflow limits and the wrapping scratch counter
  task automatic t_small_stack;
    wr(5'h0B, 16'h9020);
    `CHK("clamped limits", 16'h4020, {srl, spl})
    wr(5'h0A, 16'h1234);
    rd(5'h0A);
    `CHK("underflow", 16'h1234, sq)
    wr(5'h16, 16'hFFFF);
    sinc = 1'b1;
    @(posedge ref_clk);
    #1;
    sinc = 1'b0;
    rd(5'h16);
    `CHK("count wrap up", 16'h0000, sq)
    sdec = 1'b1;
    @(posedge ref_clk);
    #1;
    sdec = 1'b0;
    rd(5'h16);
    `CHK("count wrap down", 16'hFFFF, sq)
    wr(5'h17, 16'h5A5A);
    rd(5'h17);
    `CHK("scratch word", 16'h5A5A, sq)
  endtask

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run;
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_reset_mask;
    t_pointers_limits;
    t_reserved_products;
    t_pages;
    t_timers;
    t_small_stack;
    complete_run;
  end
endmodule
`default_nettype wire
